/* logic/tpm_status_page.sv */
`timescale 1ns/1ps
// Functional notes
// R01 - pattern error counter counts each pattern error
// R02 - pattern multiframe counter counts received multiframes
// R03 - any pattern error write zeroes multiframe counter
// R04 - alarm bit 7: yellow over long integration
// R05 - alarm bit 6: yellow over short integration
// R06 - alarm bit 5: alternate yellow, twelfth frame
// R07 - alarm bit 4: extended format yellow received
// R08 - alarm bit 3: all ones alarm received
// R09 - alarm bit 2: pulse density violation received
// R10 - alarm bits 1/0: loop up/down codes
// R11 - alarm bits stick until read, set wins
// R12 - framing error counter counts framing bit errors
// R13 - format selects which framing bits are checked
// R14 - framing count only while in frame sync
// R15 - upper nibble counts frame sync losses
// R16 - lower nibble counts alignment position changes
// R17 - multiframe sync loss counter per multiframe
// R18 - sixteen bit bipolar violation counter
// R19 - all counters wrap from all ones
module tpm_status_page import tpm_pkg::*; #(
  parameter int YELLOW_LONG_CYCLES  = YELLOW_LONG_CYC,
  parameter int YELLOW_SHORT_CYCLES = YELLOW_SHORT_CYC,
  parameter int MF_D4_CYCLES        = MF_D4_CYC,
  parameter int MF_ESF_CYCLES       = MF_ESF_CYC,
  parameter int ALIGN_W             = 8
) (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  output logic                   flags0_read,
  input  wire logic              pattern_err,
  input  wire logic              crc_multiframe,
  input  wire logic              yellow_d4_raw,
  input  wire logic              alt_yellow_det,
  input  wire logic              esf_yellow_det,
  input  wire logic              all_ones_det,
  input  wire logic              density_viol_det,
  input  wire logic              loop_up_det,
  input  wire logic              loop_down_det,
  input  wire logic              esf_mode,
  input  wire logic              fs_check_en,
  input  wire logic              ft_bit_err,
  input  wire logic              fs_bit_err,
  input  wire logic              esf_bit_err,
  input  wire logic              in_frame_sync,
  input  wire logic              resync_done,
  input  wire logic [ALIGN_W-1:0] align_pos,
  input  wire logic              bipolar_viol,
  input  wire logic              crc_err,
  input  wire logic [DATA_W-1:0] event_flags_0_in,
  input  wire logic [DATA_W-1:0] event_flags_1_in,
  input  wire logic [DATA_W-1:0] event_flags_2_in,
  input  wire logic [DATA_W-1:0] event_flags_3_in,
  input  wire logic [DATA_W-1:0] overflow_in
);
  localparam logic [ADDR_W+DATA_W+2:0] BUS_IDLE = {3'h7, {(ADDR_W+DATA_W){1'b0}}};

  logic [ADDR_W-1:0]  addr_s;
  logic [DATA_W-1:0]  data_s;
  logic               cs_n_s;
  logic               rd_n_s;
  logic               wr_n_s;
  logic               rd_act;
  logic               wr_act;
  logic               rd_act_reg;
  logic               wr_act_reg;
  logic               rd_start;
  logic               rd_end;
  logic               wr_start;
  logic               pattern_write;
  logic [DATA_W-1:0]  data_out_reg;
  logic [DATA_W-1:0]  data_out_next;
  logic               data_oe_reg;
  logic [ADDR_W-1:0]  rd_addr_reg;
  logic [ADDR_W-1:0]  rd_addr_next;
  logic               flags0_read_reg;
  logic               flags0_read_next;
  logic [DATA_W-1:0]  alarm_reg;
  logic [DATA_W-1:0]  alarm_next;
  logic [DATA_W-1:0]  alarm_set;
  logic [DATA_W-1:0]  alarm_clr;
  logic [TMR_W-1:0]   yl_tmr_reg;
  logic [TMR_W-1:0]   yl_tmr_next;
  logic [TMR_W-1:0]   ys_tmr_reg;
  logic [TMR_W-1:0]   ys_tmr_next;
  logic               yl_hit;
  logic               ys_hit;
  logic               sync_d_reg;
  logic               frame_loss;
  logic               framing_inc;
  logic [ALIGN_W-1:0] last_align_reg;
  logic [ALIGN_W-1:0] last_align_next;
  logic               realign_inc;
  logic [TMR_W-1:0]   mf_tmr_reg;
  logic [TMR_W-1:0]   mf_tmr_next;
  logic               mf_lost_reg;
  logic               mf_lost_next;
  logic               mf_tick;
  logic               mf_loss_inc;
  logic [DATA_W-1:0]  pattern_error_value;
  logic [DATA_W-1:0]  pattern_multiframe_value;
  logic [DATA_W-1:0]  framing_error_value;
  logic [NIB_W-1:0]   frame_loss_value;
  logic [NIB_W-1:0]   realign_value;
  logic [DATA_W-1:0]  multiframe_loss_value;
  logic [WIDE_CNT_W-1:0] violation_count;
  logic [WIDE_CNT_W-1:0] crc_error_count;

  // host strobes, address and data are asynchronous pins: two flops each
  tpm_sync #(.WIDTH(ADDR_W+DATA_W+3), .RST_VAL(BUS_IDLE)) u_bus_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .d        ({cs_n, rd_n, wr_n, addr, data_in}),
    .q        ({cs_n_s, rd_n_s, wr_n_s, addr_s, data_s})
  );

  // strobe edges on the synchronised copies
  assign rd_act        = !cs_n_s && !rd_n_s;
  assign wr_act        = !cs_n_s && !wr_n_s;
  assign rd_start      = rd_act && !rd_act_reg;
  assign rd_end        = !rd_act && rd_act_reg;
  assign wr_start      = wr_act && !wr_act_reg;
  assign pattern_write = wr_start && (addr_s == ADDR_PATTERN_ERR);

  // read multiplexer; holes and the unused word read as zero
  function automatic logic [DATA_W-1:0] reg_value(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_PATTERN_ERR:   reg_value = pattern_error_value;
      ADDR_PATTERN_MF:    reg_value = pattern_multiframe_value;
      ADDR_ALARM_LATCH:   reg_value = alarm_reg;
      ADDR_FRAMING_ERR:   reg_value = framing_error_value;
      ADDR_LOSS_REALIGN:  reg_value = {frame_loss_value, realign_value};
      ADDR_MF_SYNC_LOSS:  reg_value = multiframe_loss_value;
      ADDR_BPV_HI:        reg_value = violation_count[WIDE_CNT_W-1:DATA_W];
      ADDR_BPV_LO:        reg_value = violation_count[DATA_W-1:0];
      ADDR_CRC_HI:        reg_value = crc_error_count[WIDE_CNT_W-1:DATA_W];
      ADDR_CRC_LO:        reg_value = crc_error_count[DATA_W-1:0];
      ADDR_EVENT_FLAGS_0: reg_value = event_flags_0_in;
      ADDR_EVENT_FLAGS_1: reg_value = event_flags_1_in;
      ADDR_EVENT_FLAGS_2: reg_value = event_flags_2_in;
      ADDR_EVENT_FLAGS_3: reg_value = event_flags_3_in;
      ADDR_OVERFLOW:      reg_value = overflow_in;
      default:            reg_value = RESET_VALUE;
    endcase
  endfunction

  // data is captured once at read start so the host sees a stable byte
  always_comb begin
    data_out_next    = data_out_reg;
    rd_addr_next     = rd_addr_reg;
    flags0_read_next = rd_end && (rd_addr_reg == ADDR_EVENT_FLAGS_0);
    if (rd_start) begin
      data_out_next = reg_value(addr_s);
      rd_addr_next  = addr_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_act_reg      <= 1'b0;
      wr_act_reg      <= 1'b0;
      data_out_reg    <= RESET_VALUE;
      data_oe_reg     <= 1'b0;
      rd_addr_reg     <= '0;
      flags0_read_reg <= 1'b0;
    end else begin
      rd_act_reg      <= rd_act;
      wr_act_reg      <= wr_act;
      data_out_reg    <= data_out_next;
      data_oe_reg     <= rd_act;
      rd_addr_reg     <= rd_addr_next;
      flags0_read_reg <= flags0_read_next;
    end
  end

  assign data_out    = data_out_reg;
  assign data_oe     = data_oe_reg;
  assign flags0_read = flags0_read_reg;

  // yellow integration: raw indication must persist for the whole period
  assign yl_hit = yellow_d4_raw && (yl_tmr_reg == TMR_W'(YELLOW_LONG_CYCLES - 1));
  assign ys_hit = yellow_d4_raw && (ys_tmr_reg == TMR_W'(YELLOW_SHORT_CYCLES - 1));

  always_comb begin
    yl_tmr_next = '0;
    ys_tmr_next = '0;
    if (yellow_d4_raw) begin
      yl_tmr_next = yl_hit ? yl_tmr_reg : TMR_W'(yl_tmr_reg + 1'b1); // see R04
      ys_tmr_next = ys_hit ? ys_tmr_reg : TMR_W'(ys_tmr_reg + 1'b1); // see R05
    end
  end

  // alarm latch: only bits the host actually saw are cleared, set wins
  always_comb begin
    alarm_set                   = '0;
    alarm_set[BIT_YELLOW_LONG]  = yl_hit;           // see R04
    alarm_set[BIT_YELLOW_SHORT] = ys_hit;           // see R05
    alarm_set[BIT_ALT_YELLOW]   = alt_yellow_det;   // see R06
    alarm_set[BIT_ESF_YELLOW]   = esf_yellow_det;   // see R07
    alarm_set[BIT_ALL_ONES]     = all_ones_det;     // see R08
    alarm_set[BIT_DENSITY]      = density_viol_det; // see R09
    alarm_set[BIT_LOOP_UP]      = loop_up_det;      // see R10
    alarm_set[BIT_LOOP_DOWN]    = loop_down_det;    // see R10
    alarm_clr = (rd_end && rd_addr_reg == ADDR_ALARM_LATCH) ? data_out_reg : '0;
    alarm_next = (alarm_reg & ~alarm_clr) | alarm_set; // see R11
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      alarm_reg  <= RESET_VALUE;
      yl_tmr_reg <= '0;
      ys_tmr_reg <= '0;
    end else begin
      alarm_reg  <= alarm_next;
      yl_tmr_reg <= yl_tmr_next;
      ys_tmr_reg <= ys_tmr_next;
    end
  end

  // framing check set by format, gated by frame sync
  assign framing_inc = in_frame_sync && // see R14
                       (esf_mode ? esf_bit_err : (ft_bit_err || (fs_check_en && fs_bit_err))); // see R13
  assign frame_loss  = sync_d_reg && !in_frame_sync; // see R15
  assign realign_inc = resync_done && (align_pos != last_align_reg); // see R16
  assign mf_tick     = mf_tmr_reg == TMR_W'((esf_mode ? MF_ESF_CYCLES : MF_D4_CYCLES) - 1);
  assign mf_loss_inc = mf_tick && (mf_lost_reg || !in_frame_sync); // see R17

  // own multiframe timer: the framer gives no boundaries while out of sync
  always_comb begin
    last_align_next = resync_done ? align_pos : last_align_reg;
    mf_tmr_next     = mf_tick ? '0 : TMR_W'(mf_tmr_reg + 1'b1);
    mf_lost_next    = mf_tick ? 1'b0 : (mf_lost_reg || !in_frame_sync);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync_d_reg     <= 1'b0;
      last_align_reg <= '0;
      mf_tmr_reg     <= '0;
      mf_lost_reg    <= 1'b0;
    end else begin
      sync_d_reg     <= in_frame_sync;
      last_align_reg <= last_align_next;
      mf_tmr_reg     <= mf_tmr_next;
      mf_lost_reg    <= mf_lost_next;
    end
  end

  // event counters
  tpm_event_counter #(.WIDTH(DATA_W)) u_pattern_err (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inc      (pattern_err), // see R01
    .load     (pattern_write),
    .load_val (data_s),
    .count    (pattern_error_value)
  );

  tpm_event_counter #(.WIDTH(DATA_W)) u_pattern_mf (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inc      (crc_multiframe), // see R02
    .load     (pattern_write),  // see R03
    .load_val (RESET_VALUE),
    .count    (pattern_multiframe_value)
  );

  tpm_event_counter #(.WIDTH(DATA_W)) u_framing (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inc      (framing_inc), // see R12
    .load     (1'b0),
    .load_val (RESET_VALUE),
    .count    (framing_error_value)
  );

  tpm_event_counter #(.WIDTH(NIB_W)) u_frame_loss (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inc      (frame_loss),
    .load     (1'b0),
    .load_val ('0),
    .count    (frame_loss_value)
  );

  tpm_event_counter #(.WIDTH(NIB_W)) u_realign (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inc      (realign_inc),
    .load     (1'b0),
    .load_val ('0),
    .count    (realign_value)
  );

  tpm_event_counter #(.WIDTH(DATA_W)) u_mf_loss (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inc      (mf_loss_inc),
    .load     (1'b0),
    .load_val (RESET_VALUE),
    .count    (multiframe_loss_value)
  );

  tpm_event_counter #(.WIDTH(WIDE_CNT_W)) u_violation (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inc      (bipolar_viol), // see R18
    .load     (1'b0),
    .load_val ('0),
    .count    (violation_count)
  );

  tpm_event_counter #(.WIDTH(WIDE_CNT_W)) u_crc (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inc      (crc_err),
    .load     (1'b0),
    .load_val ('0),
    .count    (crc_error_count)
  );

  // checks
  sequence s_pattern_write;
    wr_start && (addr_s == ADDR_PATTERN_ERR);
  endsequence

  sequence s_alarm_read_done;
    rd_end && (rd_addr_reg == ADDR_ALARM_LATCH);
  endsequence

  a_pattern_err_step: assert property (@(posedge core_clk) disable iff (!resetn) // see R01
    pattern_err && !pattern_write |=> pattern_error_value == DATA_W'($past(pattern_error_value) + 1'b1))
    else $error("pattern error counter did not step");

  a_pattern_mf_step: assert property (@(posedge core_clk) disable iff (!resetn) // see R02
    crc_multiframe && !pattern_write
      |=> pattern_multiframe_value == DATA_W'($past(pattern_multiframe_value) + 1'b1))
    else $error("pattern multiframe counter did not step");

  a_mf_write_clear: assert property (@(posedge core_clk) disable iff (!resetn) // see R03
    s_pattern_write |=> pattern_multiframe_value == RESET_VALUE)
    else $error("pattern write did not zero multiframe counter");

  a_yellow_short_set: assert property (@(posedge core_clk) disable iff (!resetn) // see R05
    ys_hit |=> alarm_reg[BIT_YELLOW_SHORT])
    else $error("short yellow latch not set");

  a_alarm_set_wins: assert property (@(posedge core_clk) disable iff (!resetn) // see R11
    alarm_set != '0 |=> (alarm_reg & $past(alarm_set)) == $past(alarm_set))
    else $error("alarm event lost");

  a_alarm_sticky: assert property (@(posedge core_clk) disable iff (!resetn) // see R11
    !(rd_end && (rd_addr_reg == ADDR_ALARM_LATCH)) |=> (alarm_reg & $past(alarm_reg)) == $past(alarm_reg))
    else $error("alarm bit dropped without read");

  a_alarm_read_clear: assert property (@(posedge core_clk) disable iff (!resetn) // see R11
    s_alarm_read_done ##0 (alarm_set == '0) |=> (alarm_reg & $past(data_out_reg)) == '0)
    else $error("alarm bits not cleared by read");

  a_framing_hold: assert property (@(posedge core_clk) disable iff (!resetn) // see R14
    !in_frame_sync |=> $stable(framing_error_value))
    else $error("framing count moved out of sync");

  a_frame_loss_step: assert property (@(posedge core_clk) disable iff (!resetn) // see R15
    $fell(in_frame_sync) |=> frame_loss_value == NIB_W'($past(frame_loss_value) + 1'b1))
    else $error("frame loss count did not step");

  a_realign_same_pos: assert property (@(posedge core_clk) disable iff (!resetn) // see R16
    resync_done && (align_pos == last_align_reg) |=> $stable(realign_value))
    else $error("realign counted without a move");

  a_read_data: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_start |=> data_oe && (data_out == $past(reg_value(addr_s))))
    else $error("read data wrong");
endmodule

/* common/tpm_pkg.sv */
package tpm_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;
  // register map of the status page
  localparam logic [ADDR_W-1:0] ADDR_PATTERN_ERR   = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_PATTERN_MF    = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_LATCH   = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_FRAMING_ERR   = 5'h13;
  localparam logic [ADDR_W-1:0] ADDR_LOSS_REALIGN  = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_MF_SYNC_LOSS  = 5'h15;
  localparam logic [ADDR_W-1:0] ADDR_BPV_HI        = 5'h16;
  localparam logic [ADDR_W-1:0] ADDR_BPV_LO        = 5'h17;
  localparam logic [ADDR_W-1:0] ADDR_CRC_HI        = 5'h18;
  localparam logic [ADDR_W-1:0] ADDR_CRC_LO        = 5'h19;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_FLAGS_0 = 5'h1b;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_FLAGS_1 = 5'h1c;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_FLAGS_2 = 5'h1d;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_FLAGS_3 = 5'h1e;
  localparam logic [ADDR_W-1:0] ADDR_OVERFLOW      = 5'h1f;
  // alarm latch bit positions
  localparam int BIT_YELLOW_LONG  = 7;
  localparam int BIT_YELLOW_SHORT = 6;
  localparam int BIT_ALT_YELLOW   = 5;
  localparam int BIT_ESF_YELLOW   = 4;
  localparam int BIT_ALL_ONES     = 3;
  localparam int BIT_DENSITY      = 2;
  localparam int BIT_LOOP_UP      = 1;
  localparam int BIT_LOOP_DOWN    = 0;
  // nibble fields of the frame loss / realign register, and the wide counter width
  localparam int NIB_W            = 4;
  localparam int FRAME_LOSS_LSB   = 4;
  localparam int REALIGN_LSB      = 0;
  localparam int WIDE_CNT_W       = 16;
  // timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int NS_PER_MS        = 1000000;
  localparam int NS_PER_US        = 1000;
  localparam int YELLOW_LONG_MS   = 600;
  localparam int YELLOW_SHORT_MS  = 48;
  localparam int MF_D4_US         = 1500;
  localparam int MF_ESF_US        = 3000;
  localparam int YELLOW_LONG_CYC  = YELLOW_LONG_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int YELLOW_SHORT_CYC = YELLOW_SHORT_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int MF_D4_CYC        = MF_D4_US * (NS_PER_US / CLK_PERIOD_NS);
  localparam int MF_ESF_CYC       = MF_ESF_US * (NS_PER_US / CLK_PERIOD_NS);
  localparam int TMR_W            = 26;
endpackage

/* logic/tpm_sync.sv */
`timescale 1ns/1ps
module tpm_sync import tpm_pkg::*; #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // two flops; the first is read only by the second
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stage1_reg <= RST_VAL;
      stage2_reg <= RST_VAL;
    end else begin
      stage1_reg <= d;
      stage2_reg <= stage1_reg;
    end
  end

  assign q = stage2_reg;
endmodule

/* logic/tpm_event_counter.sv */
`timescale 1ns/1ps
module tpm_event_counter import tpm_pkg::*; #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             inc,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  output logic      [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // a load wins over a coincident increment; all-ones wraps to zero
  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = load_val;
    end else if (inc) begin
      count_next = WIDTH'(count_reg + 1'b1); // see R19
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
endmodule

/* sim/tpm_framer_model.sv */
`timescale 1ns/1ps
// receive framer stand-in: emits event pulses towards the status page
module tpm_framer_model (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        go,
  input  wire logic [13:0] req,
  input  wire logic [3:0]  times,
  output logic      [13:0] ev,
  output logic             busy
);
  logic [4:0] left_reg;
  logic [4:0] left_next;
  logic [13:0] ev_next;

  // pulses are separated by an idle cycle, as real line events never merge
  always_comb begin
    left_next = left_reg;
    ev_next   = '0;
    if (go) begin
      left_next = {times, 1'b0};
    end else if (left_reg != 5'h00) begin
      left_next = left_reg - 5'h01;
      ev_next   = left_reg[0] ? req : 14'h0000;
    end
  end

  // registered event outputs, so pulses land one clean cycle each
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      left_reg <= 5'h00;
      ev       <= '0;
    end else begin
      left_reg <= left_next;
      ev       <= ev_next;
    end
  end

  assign busy = (left_reg != 5'h00) || (ev != 14'h0000);
endmodule

/* sim/t1_perf_monitor_status_page_tb.sv */
`timescale 1ns/1ps
module t1_perf_monitor_status_page_tb import tpm_pkg::*;;
  logic              core_clk, resetn, cs_n, rd_n, wr_n, go, busy;
  logic              yellow_d4_raw, esf_mode, fs_check_en, in_frame_sync, data_oe, flags0_read;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_in, data_out, v0;
  logic [7:0]        align_pos;
  logic [13:0]       req, ev;
  logic [3:0]        times;
  logic [7:0]        efl [0:4];
  int                mismatches, total_checks, cyc, f0_pulses;

  tpm_status_page #(.YELLOW_LONG_CYCLES(20), .YELLOW_SHORT_CYCLES(8), .MF_D4_CYCLES(16),
    .MF_ESF_CYCLES(32), .ALIGN_W(8)) DUT (
    .core_clk, .resetn, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe, .flags0_read,
    .pattern_err(ev[0]), .crc_multiframe(ev[1]), .yellow_d4_raw, .alt_yellow_det(ev[2]),
    .esf_yellow_det(ev[3]), .all_ones_det(ev[4]), .density_viol_det(ev[5]), .loop_up_det(ev[6]),
    .loop_down_det(ev[7]), .esf_mode, .fs_check_en, .ft_bit_err(ev[8]), .fs_bit_err(ev[9]),
    .esf_bit_err(ev[10]), .in_frame_sync, .resync_done(ev[11]), .align_pos, .bipolar_viol(ev[12]),
    .crc_err(ev[13]), .event_flags_0_in(efl[0]), .event_flags_1_in(efl[1]),
    .event_flags_2_in(efl[2]), .event_flags_3_in(efl[3]), .overflow_in(efl[4]));

  tpm_framer_model FRAMER (.core_clk, .resetn, .go, .req, .times, .ev, .busy);

  always #5 core_clk = ~core_clk;

  // hang guard plus a tally of read-end pulses for the first event word
  always @(posedge core_clk) begin
    cyc++;
    if (flags0_read === 1'b1) f0_pulses++;
    if (cyc == 4000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // pins pass a two-flop sync, so strobes stay low 5 edges and high 6
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a;
    tick(5);
    chk(data_out, exp);
    chk({7'h00, data_oe}, 8'h01); // bus driven while the read strobe stands
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    tick(6);
    chk({7'h00, data_oe}, 8'h00); // bus released three edges after the strobe rises
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cs_n    <= 1'b0;
    wr_n    <= 1'b0;
    addr    <= a;
    data_in <= d;
    tick(5);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    tick(6);
  endtask

  task automatic fire(input logic [13:0] mask, input logic [3:0] n);
    req   <= mask;
    times <= n;
    go    <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(1);
    for (int k = 0; k < 40 && busy !== 1'b0; k++) tick(1);
    tick(2);
  endtask

  task automatic hold_yellow(input int n);
    yellow_d4_raw <= 1'b1;
    tick(n);
    yellow_d4_raw <= 1'b0;
    tick(2);
  endtask

  task automatic t_map();
    for (int a = 16; a < 32; a++) rdc(a[4:0], (a < 27) ? 8'h00 : efl[a-27]);
    rdc(5'h05, 8'h00); // unmapped low address reads zero
    chk(f0_pulses[7:0], 8'h01);
    $display("map test done");
  endtask

  task automatic t_pattern();
    fire(14'h0001, 4'h3);
    fire(14'h0002, 4'h5);
    rdc(ADDR_PATTERN_ERR, 8'h03);
    rdc(ADDR_PATTERN_MF, 8'h05);
    wr(ADDR_FRAMING_ERR, 8'h44);
    rdc(ADDR_FRAMING_ERR, 8'h00);
    wr(ADDR_PATTERN_ERR, 8'hfe);
    rdc(ADDR_PATTERN_ERR, 8'hfe);
    rdc(ADDR_PATTERN_MF, 8'h00);
    fire(14'h0001, 4'h2);
    rdc(ADDR_PATTERN_ERR, 8'h00);
    $display("pattern test done");
  endtask

  task automatic t_alarm();
    fire(14'h00fc, 4'h1);
    rdc(ADDR_ALARM_LATCH, 8'h3f);
    rdc(ADDR_ALARM_LATCH, 8'h00);
    hold_yellow(12);
    rdc(ADDR_ALARM_LATCH, 8'h40);
    hold_yellow(24);
    rdc(ADDR_ALARM_LATCH, 8'hc0);
    $display("alarm test done");
  endtask

  task automatic t_framing();
    fire(14'h0600, 4'h1);
    fire(14'h0100, 4'h1);
    fs_check_en <= 1'b1;
    fire(14'h0200, 4'h1);
    esf_mode <= 1'b1;
    fire(14'h0300, 4'h1);
    fire(14'h0400, 4'h1);
    in_frame_sync <= 1'b0;
    fire(14'h0400, 4'h1);
    in_frame_sync <= 1'b1;
    rdc(ADDR_FRAMING_ERR, 8'h03);
    $display("framing test done");
  endtask

  // a single-cycle sync drop costs exactly one multiframe
  task automatic t_sync();
    tick(40);
    rdc(ADDR_MF_SYNC_LOSS, 8'h01);
    in_frame_sync <= 1'b0;
    tick(1);
    in_frame_sync <= 1'b1;
    tick(40);
    rdc(ADDR_MF_SYNC_LOSS, 8'h02);
    align_pos <= 8'h05;
    fire(14'h0800, 4'h2);
    align_pos <= 8'h09;
    fire(14'h0800, 4'h1);
    rdc(ADDR_LOSS_REALIGN, 8'h22);
    fire(14'h1000, 4'h3);
    fire(14'h2000, 4'h2);
    rdc(ADDR_BPV_HI, 8'h00);
    rdc(ADDR_BPV_LO, 8'h03);
    rdc(ADDR_CRC_LO, 8'h02);
    $display("sync test done");
  endtask

  // a mid-run reset must bring the loss/realign and violation counters back to zero; the pattern error counter already reads zero
  task automatic t_reset();
    resetn <= 1'b0;
    tick(3);
    resetn <= 1'b1;
    tick(3);
    rdc(ADDR_LOSS_REALIGN, 8'h00);
    rdc(ADDR_BPV_LO, 8'h00);
    rdc(ADDR_PATTERN_ERR, 8'h00);
    $display("reset test done");
  endtask

  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    {cs_n, rd_n, wr_n} = 3'b111;
    {go, yellow_d4_raw, esf_mode, fs_check_en} = 4'h0;
    in_frame_sync = 1'b1;
    addr = 5'h00;
    data_in = 8'h00;
    align_pos = 8'h00;
    req = 14'h0000;
    times = 4'h0;
    efl = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h81};
    tick(8);
    resetn <= 1'b1;
    tick(3);
    t_map();
    t_pattern();
    t_alarm();
    t_framing();
    t_sync();
    t_reset();
    report_and_stop();
  end
endmodule
